// ### hw/bank_addr_pkg.sv
// Package: constants for banked data memory addressing
package bank_addr_pkg;
    localparam int BANK_BITS = 4;
    localparam int FILE_BITS = 8;
    localparam int ADDR_BITS = 12;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [7:0] BANK_SELECT_RESET = 8'h00;
    localparam logic [7:0] BANK_SELECT_RMASK = 8'h0f;
    localparam logic [3:0] REG_BANK_SELECT = 4'h0;
    localparam logic [3:0] REG_LAST_ADDR = 4'h4;
    localparam logic [3:0] REG_IMPL_MASK = 4'h8;
    localparam logic [15:0] IMPL_BANKS_DEFAULT = 16'hffff;
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_FILE = 2'b01,
        ACC_MOVE_SRC = 2'b11,
        ACC_MOVE_DST = 2'b10
    } acc_kind_t;
endpackage : bank_addr_pkg

// ### hw/bank_addr_if.sv
// Interface: address former request and result
`timescale 1ns/100ps
interface bank_addr_if;
    logic [7:0] file_addr;
    logic access_n;
    logic [3:0] bank;
    logic [11:0] abs_addr;
    logic use_abs;
    logic [11:0] phys_addr;
    logic bank_present;
    logic [15:0] impl_banks;
    modport core (output file_addr, access_n, bank, abs_addr, use_abs, impl_banks,
                  input phys_addr, bank_present);
    modport former (input file_addr, access_n, bank, abs_addr, use_abs, impl_banks,
                    output phys_addr, bank_present);
endinterface : bank_addr_if

// ### hw/bank_addr_former.sv
// Address former: file address plus bank to twelve-bit data address
`timescale 1ns/100ps
module bank_addr_former
    import bank_addr_pkg::*;
(
    bank_addr_if.former bus
);
    always_comb begin
        if (bus.use_abs) begin
            bus.phys_addr = bus.abs_addr;
        end else if (bus.access_n) begin
            bus.phys_addr = {bus.bank, bus.file_addr};
        end else if (bus.file_addr < ACCESS_SPLIT) begin
            bus.phys_addr = {ACCESS_LOW_BANK, bus.file_addr};
        end else begin
            bus.phys_addr = {ACCESS_HIGH_BANK, bus.file_addr};
        end
    end

    assign bus.bank_present = bus.impl_banks[bus.phys_addr[11:8]];
endmodule : bank_addr_former

// ### hw/banked_data_memory_addressing.sv
// Top: banked data memory address generation with bank select register
//
// Function
// - Window joins bank 0 low, bank 15 high
// - Access bit picks bank select or window
// - Window is contiguous low then high
// - Window high half reaches special registers
// - Sixteen selectable banks
// - Bank select low nibble is address top
// - Bank select upper nibble reads zero
// - Unimplemented bank reads zero, drops writes
// - Status flags update even when unimplemented
// - Banks are 256 bytes of static storage
// - File move uses absolute twelve-bit addresses
// - Load literal writes low nibble, no flags
// - File instructions carry eight-bit address
// - File move: source word, then destination
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module banked_data_memory_addressing
    import bank_addr_pkg::*;
#(
    parameter logic [15:0] IMPL_BANKS = IMPL_BANKS_DEFAULT
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic file_req,
    input wire logic [7:0] file_addr,
    input wire logic access_sel,
    input wire logic file_we,
    input wire logic [7:0] file_wdata,
    input wire logic move_req,
    input wire logic [11:0] move_src,
    input wire logic [11:0] move_dst,
    input wire logic load_bank_literal,
    input wire logic [7:0] bank_literal,
    input wire logic [7:0] status_in,
    input wire logic status_we,
    output logic [7:0] file_rdata,
    output logic file_rvalid,
    output logic [11:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic mem_re,
    input wire logic [7:0] mem_rdata,
    output logic [7:0] status_q,
    output logic busy,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    logic [7:0] bank_select_q;
    logic [15:0] impl_mask_q;
    logic [11:0] last_addr_q;
    logic [11:0] move_dst_q;
    logic [7:0] move_data_q;
    logic avs_done_q;
    acc_kind_t kind_q;
    acc_kind_t kind_d;
    logic [7:0] rdata_d;

    bank_addr_if fa ();
    bank_addr_former u_former (
        .bus(fa.former)
    );

    // Source read of a move is muxed in first; destination goes from the held copy
    assign fa.file_addr = file_addr;
    assign fa.access_n = access_sel;
    assign fa.bank = bank_select_q[3:0];
    assign fa.use_abs = (kind_q == ACC_MOVE_SRC) || move_req;
    assign fa.abs_addr = (kind_q == ACC_MOVE_SRC) ? move_dst_q : move_src;
    assign fa.impl_banks = impl_mask_q;

    // One file access or the source half of a move per cycle; move takes a second
    always_comb begin
        kind_d = ACC_IDLE;
        if (kind_q == ACC_MOVE_SRC) begin
            kind_d = ACC_MOVE_DST;
        end else if (move_req) begin
            kind_d = ACC_MOVE_SRC;
        end else if (file_req) begin
            kind_d = ACC_FILE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            kind_q <= ACC_IDLE;
        end else begin
            kind_q <= kind_d;
        end
    end

    // Destination half of a move; the core holds off, nothing is queued here
    assign busy = (kind_q == ACC_MOVE_SRC);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            move_dst_q <= 12'h000;
        end else if (move_req && kind_q != ACC_MOVE_SRC) begin
            move_dst_q <= move_dst;
        end
    end

    // Memory strobes: absent banks see no write and their reads become zero
    always_comb begin
        mem_addr = fa.phys_addr;
        mem_re = 1'b0;
        mem_we = 1'b0;
        mem_wdata = file_wdata;
        if (kind_q == ACC_MOVE_SRC) begin
            mem_we = fa.bank_present;
            mem_wdata = move_data_q;
        end else if (move_req) begin
            mem_re = fa.bank_present;
        end else if (file_req) begin
            mem_re = fa.bank_present && !file_we;
            mem_we = fa.bank_present && file_we;
        end
    end

    // Source byte is held so the write does not rely on read data in its own cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            move_data_q <= 8'h00;
        end else if (move_req && kind_q != ACC_MOVE_SRC) begin
            move_data_q <= fa.bank_present ? mem_rdata : 8'h00;
        end
    end

    // Read data lands one cycle after the request; absent banks return zero
    always_comb begin
        rdata_d = 8'h00;
        if (file_req && !move_req && kind_q != ACC_MOVE_SRC && !file_we && fa.bank_present) begin
            rdata_d = mem_rdata;
        end
    end

    // Read result and its valid flag stand for one cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_rdata <= 8'h00;
            file_rvalid <= 1'b0;
        end else begin
            file_rdata <= rdata_d;
            file_rvalid <= (kind_d == ACC_FILE) && !file_we;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_addr_q <= 12'h000;
        end else if (kind_d != ACC_IDLE) begin
            last_addr_q <= fa.phys_addr;
        end
    end

    // Flags follow the instruction regardless of where its operand sits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= 8'h00;
        end else if (status_we && !load_bank_literal) begin
            status_q <= status_in;
        end
    end

    // Bank select: literal load from the core, or software over the bus
    // Bus writes land only at the accepting edge, once waitrequest is low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_select_q <= BANK_SELECT_RESET;
        end else if (load_bank_literal) begin
            bank_select_q <= {4'h0, bank_literal[3:0]};
        end else if (avs_write && avs_done_q && avs_address == REG_BANK_SELECT) begin
            bank_select_q <= avs_writedata[7:0] & BANK_SELECT_RMASK;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            impl_mask_q <= 16'h0000;
        end else if (avs_done_q && avs_write && avs_address == REG_IMPL_MASK) begin
            impl_mask_q <= avs_writedata[15:0] & IMPL_BANKS;
        end else if (!avs_done_q && !avs_write && !avs_read && impl_mask_q == 16'h0000) begin
            impl_mask_q <= IMPL_BANKS;
        end
    end

    // Avalon slave: one wait cycle, request accepted on the second edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_done_q <= 1'b0;
        end else begin
            avs_done_q <= (avs_read || avs_write) && !avs_done_q;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !avs_done_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !avs_done_q) begin
            case (avs_address)
                REG_BANK_SELECT: avs_readdata <= {24'h0, bank_select_q & BANK_SELECT_RMASK};
                REG_LAST_ADDR: avs_readdata <= {20'h0, last_addr_q};
                REG_IMPL_MASK: avs_readdata <= {16'h0, impl_mask_q};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Checks
    chk_window_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (file_req && !move_req && !busy && !access_sel && file_addr < 8'h80)
        |-> mem_addr == {4'h0, file_addr}) else $error("window low map wrong");
    chk_window_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (file_req && !move_req && !busy && !access_sel && file_addr >= 8'h80)
        |-> mem_addr[11:8] == 4'hf) else $error("window high map wrong");
    chk_banked_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (file_req && !move_req && !busy && access_sel)
        |-> mem_addr == {bank_select_q[3:0], file_addr}) else $error("banked map wrong");
    chk_upper_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bank_select_q[7:4] == 4'h0) else $error("bank select upper bits set");
    chk_literal_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        load_bank_literal |=> bank_select_q[3:0] == $past(bank_literal[3:0]))
        else $error("literal load lost");
    chk_absent_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mem_we |-> impl_mask_q[mem_addr[11:8]]) else $error("write to absent bank");
    sequence move_start_s;
        move_req && !busy;
    endsequence
    chk_move_src: assert property (@(posedge ref_clk) disable iff (!rst_n)
        move_start_s |-> mem_addr == move_src) else $error("move source address wrong");
    chk_move_dst: assert property (@(posedge ref_clk) disable iff (!rst_n)
        move_start_s |=> busy && mem_addr == $past(move_dst)) else $error("move dest wrong");
    chk_absent_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (file_req && !move_req && !busy && !file_we && !impl_mask_q[mem_addr[11:8]])
        |=> file_rdata == 8'h00) else $error("absent bank read not zero");

    // Flags: a literal load keeps them, any other flag write lands
    chk_literal_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
        load_bank_literal |=> status_q == $past(status_q))
        else $error("literal load changed flags");
    chk_flag_update: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (status_we && !load_bank_literal) |=> status_q == $past(status_in))
        else $error("flag update lost");

    // File access results and strobes
    sequence window_access_s;
        file_req && !move_req && !busy && !access_sel;
    endsequence
    chk_window_join: assert property (@(posedge ref_clk) disable iff (!rst_n)
        window_access_s |-> mem_addr == {(file_addr[7] ? 4'hf : 4'h0), file_addr})
        else $error("window not contiguous");
    chk_read_valid: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (file_req && !move_req && !busy && !file_we) |=> file_rvalid)
        else $error("read result missing");
    chk_write_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (file_req && file_we) |=> !file_rvalid)
        else $error("write produced read result");
    chk_absent_strobe: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mem_re |-> impl_mask_q[mem_addr[11:8]])
        else $error("read strobe to absent bank");
    chk_idle_strobes: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!file_req && !move_req && !busy) |-> !mem_we && !mem_re)
        else $error("memory strobe without access");
    chk_last_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (file_req && !move_req && !busy) |=> last_addr_q == $past(mem_addr))
        else $error("last address not kept");

    // Move: the destination cycle writes the byte held from the source cycle
    chk_move_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        move_start_s |-> mem_re == impl_mask_q[mem_addr[11:8]])
        else $error("move read strobe wrong");
    chk_move_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        move_start_s |=> mem_we == impl_mask_q[mem_addr[11:8]])
        else $error("move write strobe wrong");
    chk_move_absent: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (move_req && !busy && !impl_mask_q[mem_addr[11:8]]) |=> mem_wdata == 8'h00)
        else $error("absent move source not zero");

    // Bus: one wait cycle per request, writes land at the accepting edge
    sequence bus_wait_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    chk_bus_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bus_wait_s ##1 (avs_read || avs_write) |-> !avs_waitrequest)
        else $error("bus answer late");
    chk_bus_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("wait without request");
    chk_bank_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (avs_write && !avs_waitrequest && !load_bank_literal
            && avs_address == REG_BANK_SELECT)
        |=> bank_select_q == ($past(avs_writedata[7:0]) & 8'h0f))
        else $error("bank select write wrong");
endmodule : banked_data_memory_addressing

// ### tb/data_ram_model.sv
// Behavioural static data RAM on the far side of the address former
`timescale 1ns/100ps
module data_ram_model (
    input wire logic ref_clk,
    input wire logic [11:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    input wire logic mem_re,
    output logic [7:0] mem_rdata
);
    logic [7:0] ram [0:4095];
    initial begin
        for (int i = 0; i < 4096; i++) begin
            ram[i] = 8'h00;
        end
    end
    // Unread cycles show inverted data so a stale capture is caught
    always_comb mem_rdata = mem_re ? ram[mem_addr] : ~ram[mem_addr];
    always @(posedge ref_clk) begin
        if (mem_we) begin
            ram[mem_addr] <= mem_wdata;
        end
    end
endmodule : data_ram_model

// ### tb/banked_data_memory_addressing_tb_top.sv
// Testbench: banked addressing against a reference model
`timescale 1ns/100ps
module banked_data_memory_addressing_tb_top;
    import bank_addr_pkg::*;
    localparam logic [15:0] IMPL = 16'hbfff;
    logic ref_clk = 0, rst_n = 0, file_req = 0, access_sel = 0, file_we = 0, move_req = 0;
    logic load_bank_literal = 0, status_we = 0, avs_read = 0, avs_write = 0;
    logic [7:0] file_addr = 0, file_wdata = 0, bank_literal = 0, status_in = 0;
    logic [11:0] move_src = 0, move_dst = 0;
    logic [3:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, rd;
    logic [7:0] file_rdata, mem_wdata, mem_rdata, status_q, st_q, fa_r;
    logic [11:0] mem_addr;
    logic file_rvalid, mem_we, mem_re, busy, avs_waitrequest;
    logic [7:0] ref_mem [0:4095];
    logic [15:0] impl = IMPL;
    logic [3:0] bsel = 0;
    integer mismatches = 0, cmp_count = 0, seed = 32'h89c82e46;
    always #2 ref_clk = ~ref_clk;
    banked_data_memory_addressing #(.IMPL_BANKS(IMPL)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
        .file_req(file_req), .file_addr(file_addr), .access_sel(access_sel),
        .file_we(file_we), .file_wdata(file_wdata), .move_req(move_req),
        .move_src(move_src), .move_dst(move_dst), .load_bank_literal(load_bank_literal),
        .bank_literal(bank_literal), .status_in(status_in), .status_we(status_we),
        .file_rdata(file_rdata), .file_rvalid(file_rvalid), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
        .status_q(status_q), .busy(busy), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    data_ram_model ram (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
        integer n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= wd;
        // Waitrequest is looked at on the rising edge where the request is taken
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            mismatches++;
            give_verdict;
        end else begin
            rd = avs_readdata;
            avs_read <= 0;
            avs_write <= 0;
        end
    endtask : bus
    task ld(input logic [7:0] lit);
        @(posedge ref_clk);
        load_bank_literal <= 1;
        bank_literal <= lit;
        status_in <= ~st_q;
        status_we <= 1;
        @(posedge ref_clk);
        load_bank_literal <= 0;
        status_we <= 0;
        bsel = lit[3:0];
        @(negedge ref_clk);
        check(status_q, st_q);
    endtask : ld
    task facc(input logic s, input logic [7:0] fa, input logic we, input logic [7:0] wd);
        logic [11:0] a;
        logic [7:0] e;
        a = s ? {bsel, fa} : {(fa < 8'h80) ? 4'h0 : 4'hf, fa};
        st_q = 8'($random(seed));
        @(posedge ref_clk);
        file_req <= 1;
        access_sel <= s;
        file_addr <= fa;
        file_we <= we;
        file_wdata <= wd;
        status_in <= st_q;
        status_we <= 1;
        @(negedge ref_clk);
        check(mem_addr, a);
        check(mem_we, we && impl[a[11:8]]);
        check(mem_re, !we && impl[a[11:8]]);
        e = impl[a[11:8]] ? ref_mem[a] : 8'h00;
        if (we && impl[a[11:8]]) ref_mem[a] = wd;
        @(posedge ref_clk);
        file_req <= 0;
        file_we <= 0;
        status_we <= 0;
        @(negedge ref_clk);
        check(status_q, st_q);
        if (!we) check({file_rvalid, file_rdata}, {1'b1, e});
    endtask : facc
    task mv(input logic [11:0] s, input logic [11:0] d);
        logic [7:0] e;
        e = impl[s[11:8]] ? ref_mem[s] : 8'h00;
        @(posedge ref_clk);
        move_req <= 1;
        move_src <= s;
        move_dst <= d;
        @(negedge ref_clk);
        check({mem_re, mem_addr}, {impl[s[11:8]], s});
        @(posedge ref_clk);
        move_req <= 0;
        @(negedge ref_clk);
        check({busy, mem_addr}, {1'b1, d});
        check(mem_we, impl[d[11:8]]);
        check(mem_wdata, e);
        if (impl[d[11:8]]) ref_mem[d] = e;
    endtask : mv
    initial begin
        st_q = 0;
        for (int i = 0; i < 4096; i++) begin
            ref_mem[i] = 8'h00;
        end
        repeat (20) @(posedge ref_clk);
        rst_n <= 1;
        repeat (2) @(posedge ref_clk);
        bus(0, REG_BANK_SELECT, 0);
        check(rd, 32'h0);
        bus(0, REG_IMPL_MASK, 0);
        check(rd, {16'h0, IMPL});
        bus(1, REG_BANK_SELECT, 32'hff);
        bus(0, REG_BANK_SELECT, 0);
        check(rd, 32'h0f);
        bus(1, 4'hc, 32'hffffffff);
        bus(0, 4'hc, 0);
        check(rd, 32'h0);
        $display("register test done");
        for (int b = 0; b < 16; b++) begin
            ld({4'($random(seed)), 4'(b)});
            bus(0, REG_BANK_SELECT, 0);
            check(rd, {28'h0, 4'(b)});
            fa_r = 8'($random(seed));
            facc(1, fa_r, 1, 8'($random(seed)));
            facc(1, fa_r, 0, 0);
        end
        $display("bank test done");
        for (int i = 0; i < 4; i++) begin
            facc(0, (i[0] ? 8'h7f : 8'h00) ^ (i[1] ? 8'hff : 8'h00), 1, 8'($random(seed)));
            facc(0, (i[0] ? 8'h7f : 8'h00) ^ (i[1] ? 8'hff : 8'h00), 0, 0);
        end
        bus(0, REG_LAST_ADDR, 0);
        check(rd, 32'h0000_0f80);
        $display("window test done");
        bus(1, REG_IMPL_MASK, 32'h0000fff7);
        impl = IMPL & 16'hfff7;
        ld(8'h03);
        facc(1, 8'h42, 1, 8'h5a);
        facc(1, 8'h42, 0, 0);
        for (int i = 0; i < 8; i++) begin
            ld(8'($random(seed)));
            mv(12'($random(seed)), 12'($random(seed)));
        end
        $display("move test done");
        give_verdict;
    end
endmodule : banked_data_memory_addressing_tb_top
